// File: hdl/startup_speed_detect_config.v
// startup speed detection setup register with field decode and brake timing
// Notes on behaviour
// - 32-bit setup register at offset 0x80, resets to all zeros.
// - rejoin speed code 0..9 gives 5% to 50%; 10..15 flagged invalid.
// - brake turns on all high-side FETs at side bit 0, low-side at 1.
// - exit policy 0 leaves brake only when braking duration elapses.
// - exit policy 1 uses current threshold and duration to leave brake.
// - exit current code 0..5 gives 0.062 A to 1.25 A; 6,7 invalid.
// - standstill BEMF code 0..7 gives 50 mV to 1500 mV.
// - reverse open-loop code 0..10 gives 2.5% to 50%; others invalid.
`timescale 1ns/100ps
`include "speed_detect_map.vh"
module startup_speed_detect_config #(
    parameter MS_CYC = `MS_CYCLES
) (
    // clock and reset
    input  wire        clock_i,
    input  wire        rstn_i,
    // register access port
    input  wire [23:0] addr_i,
    input  wire        wr_i,
    input  wire [31:0] wdata_i,
    input  wire        rd_i,
    output reg  [31:0] rdata_o,
    output reg         rvalid_o,
    // braking control from motor algorithm
    input  wire        brake_req_i,
    input  wire        brake_cur_below_i,
    output reg         brake_active_o,
    output reg  [2:0]  high_fets_on_o,
    output reg  [2:0]  low_fets_on_o,
    // decoded settings
    output reg  [31:0] setup_o,
    output reg  [9:0]  rejoin_pct_x10_o,
    output reg  [10:0] exit_ma_o,
    output reg  [10:0] bemf_mv_o,
    output reg  [9:0]  rev_ol_pct_x10_o,
    output reg         code_invalid_o
);

    // prescaler width fits the cycles-per-ms count, at least two bits
    localparam integer MS_W      = (MS_CYC > 2) ? $clog2(MS_CYC) : 2;
    localparam integer MS_LAST_I = (MS_CYC > 1) ? MS_CYC - 1 : 0;
    // brake states
    localparam [0:0]   BRK_IDLE  = 1'b0;
    localparam [0:0]   BRK_HOLD  = 1'b1;

    // register, brake timers and state
    reg  [31:0]     setup_q;
    reg  [MS_W-1:0] ms_q;
    reg  [14:0]     dur_ms_q;
    reg  [0:0]      brake_q;
    // field codes of the stored word
    wire [3:0]      rejoin_c = setup_q[`F_REJOIN_HI:`F_REJOIN_LO];
    wire [2:0]      cur_c    = setup_q[`F_EXIT_CUR_HI:`F_EXIT_CUR_LO];
    wire [2:0]      bemf_c   = setup_q[`F_BEMF_HI:`F_BEMF_LO];
    wire [3:0]      rev_c    = setup_q[`F_REV_OL_HI:`F_REV_OL_LO];
    wire [3:0]      brk_c    = setup_q[`F_BRK_DUR_HI:`F_BRK_DUR_LO];
    wire            hit      = (addr_i == `SETUP_OFFSET);
    // prescaler end count and step, cut to the counter width
    wire [MS_W-1:0] ms_last  = MS_LAST_I[MS_W-1:0];
    wire [MS_W-1:0] ms_one   = {{(MS_W-1){1'b0}}, 1'b1};

    // duration code to milliseconds
    function [14:0] dur_ms;
        input [3:0] c;
        begin
            case (c)
                4'h0: dur_ms = 15'd10;
                4'h1: dur_ms = 15'd50;
                4'h2: dur_ms = 15'd100;
                4'h3: dur_ms = 15'd200;
                4'h4: dur_ms = 15'd300;
                4'h5: dur_ms = 15'd400;
                4'h6: dur_ms = 15'd500;
                4'h7: dur_ms = 15'd750;
                4'h8: dur_ms = 15'd1000;
                4'h9: dur_ms = 15'd2000;
                4'ha: dur_ms = 15'd3000;
                4'hb: dur_ms = 15'd4000;
                4'hc: dur_ms = 15'd5000;
                4'hd: dur_ms = 15'd7500;
                4'he: dur_ms = 15'd10000;
                default: dur_ms = 15'd15000;
            endcase
        end
    endfunction

    // brake target in ms and its end test, shared by count and exit
    wire [14:0]     brk_ms   = dur_ms(brk_c);
    wire            dur_done = (dur_ms_q >= brk_ms);

    // true for codes past the last applicable one of a field
    function past_last;
        input [3:0] c;
        input [3:0] last;
        begin
            past_last = (c > last);
        end
    endfunction

    // register write and read port
    always @(posedge clock_i) begin
        if (!rstn_i) begin
            setup_q  <= `SETUP_RESET;
            rdata_o  <= 32'h00000000;
            rvalid_o <= 1'b0;
        end else begin
            if (wr_i && hit)
                setup_q <= wdata_i;
            rvalid_o <= rd_i;
            // unmapped or idle reads give zero, so no stale word leaks;
            // a read in the cycle of a write still returns the old word
            rdata_o  <= (rd_i && hit) ? setup_q : 32'h00000000;
        end
    end

    // brake state machine: entry needs both enables, exit per policy
    always @(posedge clock_i) begin
        if (!rstn_i) begin
            brake_q  <= BRK_IDLE;
            ms_q     <= {MS_W{1'b0}};
            dur_ms_q <= 15'h0000;
        end else begin
            case (brake_q)
                BRK_IDLE: begin
                    // timers restart from zero on every entry
                    ms_q     <= {MS_W{1'b0}};
                    dur_ms_q <= 15'h0000;
                    if (brake_req_i && setup_q[`F_SENSE_EN]
                        && setup_q[`F_BRAKE_EN])
                        brake_q <= BRK_HOLD;
                end
                BRK_HOLD: begin
                    // millisecond prescaler
                    if (ms_q == ms_last) begin
                        ms_q <= {MS_W{1'b0}};
                        // stop at the target so a long wait cannot wrap
                        if (!dur_done)
                            dur_ms_q <= dur_ms_q + 15'd1;
                    end else begin
                        ms_q <= ms_q + ms_one;
                    end
                    // policy 1 waits for low current once time is up
                    if (dur_done) begin
                        if (!setup_q[`F_EXIT_POLICY])
                            brake_q <= BRK_IDLE;
                        else if (brake_cur_below_i)
                            brake_q <= BRK_IDLE;
                    end
                end
                default: brake_q <= BRK_IDLE;
            endcase
        end
    end

    // decoded outputs
    // all decodes are registered so every output comes from a flip-flop
    always @(posedge clock_i) begin
        if (!rstn_i) begin
            brake_active_o   <= 1'b0;
            high_fets_on_o   <= 3'h0;
            low_fets_on_o    <= 3'h0;
            setup_o          <= `SETUP_RESET;
            rejoin_pct_x10_o <= 10'h000;
            exit_ma_o        <= 11'h000;
            bemf_mv_o        <= 11'h000;
            rev_ol_pct_x10_o <= 10'h000;
            code_invalid_o   <= 1'b0;
        end else begin
            // brake state and fet banks follow the state by one cycle
            brake_active_o <= brake_q;
            high_fets_on_o <= {3{brake_q & ~setup_q[`F_FET_SIDE]}};
            low_fets_on_o  <= {3{brake_q & setup_q[`F_FET_SIDE]}};
            setup_o        <= setup_q;
            // rejoin speed in tenths of a percent
            rejoin_pct_x10_o <= past_last(rejoin_c, 4'h9) ? 10'h000 :
                10'd50 * {6'h00, rejoin_c} + 10'd50;
            // exit current in mA
            case (cur_c)
                3'h0: exit_ma_o <= 11'd62;
                3'h1: exit_ma_o <= 11'd125;
                3'h2: exit_ma_o <= 11'd187;
                3'h3: exit_ma_o <= 11'd312;
                3'h4: exit_ma_o <= 11'd625;
                3'h5: exit_ma_o <= 11'd1250;
                default: exit_ma_o <= 11'd0;
            endcase
            // standstill level in mV
            case (bemf_c)
                3'h0: bemf_mv_o <= 11'd50;
                3'h1: bemf_mv_o <= 11'd75;
                3'h2: bemf_mv_o <= 11'd100;
                3'h3: bemf_mv_o <= 11'd250;
                3'h4: bemf_mv_o <= 11'd500;
                3'h5: bemf_mv_o <= 11'd750;
                3'h6: bemf_mv_o <= 11'd1000;
                default: bemf_mv_o <= 11'd1500;
            endcase
            // reverse handoff speed in tenths of a percent
            case (rev_c)
                4'h0: rev_ol_pct_x10_o <= 10'd25;
                4'h1: rev_ol_pct_x10_o <= 10'd50;
                4'h2: rev_ol_pct_x10_o <= 10'd75;
                4'h3: rev_ol_pct_x10_o <= 10'd100;
                4'h4: rev_ol_pct_x10_o <= 10'd125;
                4'h5: rev_ol_pct_x10_o <= 10'd150;
                4'h6: rev_ol_pct_x10_o <= 10'd200;
                4'h7: rev_ol_pct_x10_o <= 10'd250;
                4'h8: rev_ol_pct_x10_o <= 10'd300;
                4'h9: rev_ol_pct_x10_o <= 10'd400;
                4'ha: rev_ol_pct_x10_o <= 10'd500;
                default: rev_ol_pct_x10_o <= 10'd0;
            endcase
            // any not-applicable code among the three limited fields
            code_invalid_o <= past_last(rejoin_c, 4'h9)
                              | past_last({1'b0, cur_c}, 4'h5)
                              | past_last(rev_c, 4'ha);
        end
    end

endmodule

// File: shared/speed_detect_map.vh
// offsets, field positions, reset value and timing counts of the setup register
`ifndef SPEED_DETECT_MAP_VH
`define SPEED_DETECT_MAP_VH
`define SETUP_OFFSET      24'h000080
`define SETUP_RESET       32'h00000000
`define F_PARITY          31
`define F_SENSE_EN        30
`define F_BRAKE_EN        29
`define F_FLOAT_EN        28
`define F_REVERSE_EN      27
`define F_REJOIN_EN       26
`define F_REJOIN_HI       25
`define F_REJOIN_LO       22
`define F_FET_SIDE        21
`define F_EXIT_POLICY     20
`define F_EXIT_CUR_HI     19
`define F_EXIT_CUR_LO     17
`define F_BRK_DUR_HI      16
`define F_BRK_DUR_LO      13
`define F_FLOAT_DUR_HI    12
`define F_FLOAT_DUR_LO    9
`define F_BEMF_HI         8
`define F_BEMF_LO         6
`define F_REV_OL_HI       5
`define F_REV_OL_LO       2
`define F_REV_DRV_HI      1
`define F_REV_DRV_LO      0
// time unit for durations: 1 ms at 100 MHz
`define MS_NS             100_0000
`define CLK_NS            10
`define MS_CYCLES         (`MS_NS / `CLK_NS)
`endif

// File: verification/host.sv
// host access model for the setup register
`timescale 1ns/100ps
module host (
    // register access
    input  wire        clock_i,
    output reg  [23:0] addr_o = 24'h0,
    output reg         wr_o = 1'b0,
    output reg  [31:0] wdata_o = 32'h0,
    output reg         rd_o = 1'b0,
    input  wire [31:0] rdata_i
);
    // one-cycle write, mapped offset only
    task wr(input [31:0] d);
        @(negedge clock_i);
        addr_o = 24'h80;
        wdata_o = d;
        wr_o = 1'b1;
        @(negedge clock_i);
        wr_o = 1'b0;
        wdata_o = ~d;
    endtask
    // one-cycle read, data taken after the answer edge
    task rd(input [23:0] a, output [31:0] d);
        @(negedge clock_i);
        addr_o = a;
        rd_o = 1'b1;
        @(negedge clock_i);
        rd_o = 1'b0;
        d = rdata_i;
    endtask
endmodule

// File: verification/startup_speed_detect_config_monitor.sv
// checker of the setup register ports
`timescale 1ns/100ps
module setup_rules_monitor (
    // watched ports
    input wire        clock_i,
    input wire        rstn_i,
    input wire [23:0] addr_i,
    input wire        rd_i,
    input wire [31:0] rdata_o,
    input wire        rvalid_o,
    input wire        brake_active_o,
    input wire [2:0]  high_fets_on_o,
    input wire [2:0]  low_fets_on_o,
    input wire [31:0] setup_o,
    input wire [9:0]  rejoin_pct_x10_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    wire [3:0] rj = setup_o[25:22];
    // read answers and register image
    property p_rv; rd_i |=> rvalid_o; endproperty
    a_rv: assert property (p_rv) else $error("no read answer");
    property p_rd; rd_i && addr_i == 24'h80 |=> rdata_o == setup_o; endproperty
    a_rd: assert property (p_rd) else $error("read data");
    property p_un; rd_i && addr_i != 24'h80 |=> rdata_o == 32'h0; endproperty
    a_un: assert property (p_un) else $error("unmapped read");
    // braking fet side and enables
    property p_hi; brake_active_o |-> high_fets_on_o == {3{~setup_o[21]}};
    endproperty
    a_hi: assert property (p_hi) else $error("high fets");
    property p_lo; brake_active_o |-> low_fets_on_o == {3{setup_o[21]}};
    endproperty
    a_lo: assert property (p_lo) else $error("low fets");
    property p_off;
        !brake_active_o |-> (high_fets_on_o | low_fets_on_o) == 3'h0;
    endproperty
    a_off: assert property (p_off) else $error("fets idle");
    property p_en; $rose(brake_active_o) |-> setup_o[30] && setup_o[29];
    endproperty
    a_en: assert property (p_en) else $error("brake enable");
    // rejoin speed decode
    property p_rj; $past(rstn_i, 2) |-> rejoin_pct_x10_o ==
        (rj > 4'h9 ? 10'h0 : 10'h32 * (rj + 10'h1)); endproperty
    a_rj: assert property (p_rj) else $error("rejoin decode");
endmodule
bind startup_speed_detect_config setup_rules_monitor i_setup_rules_monitor (
    .clock_i         (clock_i),
    .rstn_i          (rstn_i),
    .addr_i          (addr_i),
    .rd_i            (rd_i),
    .rdata_o         (rdata_o),
    .rvalid_o        (rvalid_o),
    .brake_active_o  (brake_active_o),
    .high_fets_on_o  (high_fets_on_o),
    .low_fets_on_o   (low_fets_on_o),
    .setup_o         (setup_o),
    .rejoin_pct_x10_o(rejoin_pct_x10_o)
);

// File: verification/test_startup_speed_detect_config.sv
// self-checking bench of the setup register
`timescale 1ns/100ps
module test_startup_speed_detect_config;
    localparam [87:0] MA = {22'h0, 11'h4e2, 11'h271, 11'h138, 11'hbb,
        11'h7d, 11'h3e};
    localparam [87:0] MV = {11'h5dc, 11'h3e8, 11'h2ee, 11'h1f4, 11'hfa,
        11'h64, 11'h4b, 11'h32};
    localparam [159:0] RV = {50'h0, 10'h1f4, 10'h190, 10'h12c, 10'hfa,
        10'hc8, 10'h96, 10'h7d, 10'h64, 10'h4b, 10'h32, 10'h19};
    reg         clock_i = 1'b0;
    reg         rstn_i = 1'b0;
    reg         req = 1'b0;
    reg         low_cur = 1'b0;
    reg  [31:0] d;
    integer     err_count = 0;
    integer     checked = 0;
    integer     i;
    integer     n;
    wire [23:0] addr;
    wire [31:0] wdata, rdata;
    wire        wr, rd, act, inv;
    wire [2:0]  hi, lo;
    wire [9:0]  rj, rv;
    wire [10:0] ma, mv;
    // clock and parts
    initial forever #5 clock_i = ~clock_i;
    host i_host (.clock_i(clock_i), .addr_o(addr), .wr_o(wr),
        .wdata_o(wdata), .rd_o(rd), .rdata_i(rdata));
    startup_speed_detect_config #(.MS_CYC(10)) i_startup_speed_detect_config
        (.clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr), .wr_i(wr),
        .wdata_i(wdata), .rd_i(rd), .rdata_o(rdata), .rvalid_o(),
        .brake_req_i(req), .brake_cur_below_i(low_cur), .brake_active_o(act),
        .high_fets_on_o(hi), .low_fets_on_o(lo), .setup_o(),
        .rejoin_pct_x10_o(rj), .exit_ma_o(ma), .bemf_mv_o(mv),
        .rev_ol_pct_x10_o(rv), .code_invalid_o(inv));
    // compare and count
    task chk(input [31:0] g, input [31:0] e);
        checked = checked + 1;
        if (g !== e) begin
            err_count = err_count + 1;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    // bounded wait for brake state; running out counts as a mismatch
    task wait_act(input v);
        n = 0;
        while (act !== v && n < 300) begin
            @(negedge clock_i);
            n = n + 1;
        end
        if (act !== v) begin
            err_count = err_count + 1;
            $display("[ERR] %0t got %h exp %h", $time, act, v);
        end
    endtask
    task print_verdict;
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // watchdog
    initial begin
        #200000;
        err_count = err_count + 1;
        print_verdict;
    end
    // test sequence
    initial begin
        repeat (10) @(negedge clock_i);
        rstn_i = 1'b1;
        i_host.rd(24'h80, d);
        chk(d, 32'h0);
        i_host.wr(32'hfc00_0000);
        i_host.rd(24'h80, d);
        chk(d, 32'hfc00_0000);
        i_host.rd(24'h84, d);
        chk(d, 32'h0);
        // the limited fields reach their not-applicable codes at different steps, reverse counting down
        for (i = 0; i < 16; i = i + 1) begin
            i_host.wr(i << 22 | i % 8 << 17 | i % 8 << 6
                | (15 - i) << 2);
            repeat (2) @(negedge clock_i);
            chk(32'(rj), i < 10 ? 50 * (i + 1) : 0);
            chk(32'(ma), 32'(MA[i % 8 * 11 +: 11]));
            chk(32'(mv), 32'(MV[i % 8 * 11 +: 11]));
            chk(32'(rv), 32'(RV[(15 - i) * 10 +: 10]));
            chk(32'(inv), 32'(i > 9 || i % 8 > 5 || i < 5));
        end
        // brake enable without the sense enable must not brake
        i_host.wr(32'h2020_0000);
        req = 1'b1;
        repeat (4) @(negedge clock_i);
        chk(32'(act), 32'h0);
        req = 1'b0;
        // low-side brake, exit on time alone; the request is a pulse
        i_host.wr(32'h6020_0000);
        req = 1'b1;
        wait_act(1'b1);
        req = 1'b0;
        chk(32'(lo), 32'h7);
        wait_act(1'b0);
        chk(32'(n > 94 && n < 106), 32'h1);
        // high-side brake, exit needs time and low current
        i_host.wr(32'h6010_0000);
        req = 1'b1;
        wait_act(1'b1);
        req = 1'b0;
        chk(32'(hi), 32'h7);
        repeat (150) @(negedge clock_i);
        chk(32'(act), 32'h1);
        low_cur = 1'b1;
        wait_act(1'b0);
        chk(32'(n < 4), 32'h1);
        print_verdict;
    end
endmodule
